// ### core/urx_rx_ctrl.sv
// Receive path with address detection, wake and receive interrupt control
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module urx_rx_ctrl #(
  parameter int DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        rx_pin,
  input  wire logic        low_power_mode,
  output logic             uart_irq,
  output logic             wake_req
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]                   ctrl;
  logic [7:0]                   divisor;
  logic                         word_length_select;
  logic                         overrun_error_flag;
  logic                         irq_flag;
  logic                         rda_prev;
  urx_pkg::urx_state_t          state;
  urx_pkg::urx_state_t          next_state;
  logic [3:0]                   sub_cnt;
  logic [3:0]                   bit_cnt;
  logic [urx_pkg::WORD_W-1:0]   shreg;
  logic                         push_valid;
  logic [urx_pkg::ENTRY_W-1:0]  push_data;
  logic                         wake_edge;
  logic                         wake_s1;
  logic                         wake_s2;
  logic                         wake_clr;
  logic                         baud_tick;

  urx_stream_if #(.W(urx_pkg::ENTRY_W)) push_if ();
  urx_stream_if #(.W(urx_pkg::ENTRY_W)) pop_if ();

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  wire        req          = read | write;
  wire        accept       = req & ~waitrequest;
  wire        wr_ok        = write & accept;
  wire        sel_ctrl     = hit(address, urx_pkg::OFF_CTRL);
  wire        sel_div      = hit(address, urx_pkg::OFF_DIVISOR);
  wire        sel_cfg      = hit(address, urx_pkg::OFF_CONFIG);
  wire        sel_status   = hit(address, urx_pkg::OFF_STATUS);
  wire        sel_data     = hit(address, urx_pkg::OFF_DATA);
  wire        baud_high_speed_select = ctrl[urx_pkg::CTRL_BAUD_HIGH];
  wire        address_detect_enable  = ctrl[urx_pkg::CTRL_ADDR_DET];
  wire        wake_enable            = ctrl[urx_pkg::CTRL_WAKE_EN];
  wire        receive_irq_enable     = ctrl[urx_pkg::CTRL_RX_IRQ_EN];
  wire        receive_data_available_flag = pop_if.valid;
  wire        pop          = read & accept & sel_data;
  wire        clr_overrun  = wr_ok & sel_status & writedata[urx_pkg::ST_OVERRUN];
  wire        clr_irq      = wr_ok & sel_status & writedata[urx_pkg::ST_IRQ];

  // ****************************************
  // Frame assembly
  // ****************************************
  wire [3:0]  frame_bits   = word_length_select ? urx_pkg::BITS_LONG : urx_pkg::BITS_SHORT;
  wire [8:0]  word         = word_length_select ? shreg : {1'b0, shreg[8:1]};
  wire        received_bit_seven = word[urx_pkg::BIT_SEVEN];
  wire        received_ninth_bit = word[urx_pkg::DATA_NINTH];
  wire        marker       = word_length_select ? received_ninth_bit : received_bit_seven;
  wire        is_address   = address_detect_enable & marker;
  wire        keep_word    = ~address_detect_enable | marker;
  wire        at_mid       = baud_tick & (sub_cnt == urx_pkg::SAMPLE_MID);
  wire        at_last      = baud_tick & (sub_cnt == urx_pkg::SAMPLE_LAST);
  wire        frame_done   = (state == urx_pkg::URX_STOP) & at_last;
  wire        frame_ok     = frame_done & rx_pin;
  wire        overrun_set  = push_valid & ~push_if.ready;
  wire        rda_rise     = receive_data_available_flag & ~rda_prev;
  wire        irq_set      = receive_irq_enable & (rda_rise | overrun_set);
  wire        wake_gate    = wake_enable & low_power_mode;
  wire        wake_arm_n   = rst_n & ~wake_clr;

  always_comb begin
    next_state = state;
    case (state)
      urx_pkg::URX_IDLE:  if (!rx_pin) next_state = urx_pkg::URX_START;
      urx_pkg::URX_START: if (at_mid) next_state = rx_pin ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
      urx_pkg::URX_DATA:  if (at_last && bit_cnt == frame_bits - 4'h1) next_state = urx_pkg::URX_STOP;
      urx_pkg::URX_STOP:  if (at_last) next_state = urx_pkg::URX_IDLE;
      default:            next_state = urx_pkg::URX_IDLE;
    endcase
  end

  // ****************************************
  // Leaf blocks
  // ****************************************
  urx_baud_gen #(.DIV_W(8)) i_urx_baud_gen (
    .clk        (clk),
    .rst_n      (rst_n),
    .high_speed (baud_high_speed_select),
    .divisor    (divisor),
    .tick       (baud_tick)
  );

  assign push_if.valid = push_valid;
  assign push_if.data  = push_data;
  assign pop_if.ready  = pop;

  urx_buffer #(.DEPTH(DEPTH)) i_urx_buffer (
    .clk   (clk),
    .rst_n (rst_n),
    .wr    (push_if),
    .rd    (pop_if)
  );

  // ****************************************
  // Receiver
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= urx_pkg::URX_IDLE;
      sub_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      shreg   <= '0;
    end else begin
      state   <= next_state;
      // Counter restarts at the start-bit mid sample so each data sample lands centred
      sub_cnt <= (state == urx_pkg::URX_IDLE) ? 4'h0 : (at_mid && state == urx_pkg::URX_START) ? 4'h0
                 : baud_tick ? sub_cnt + 4'h1 : sub_cnt;
      if (state == urx_pkg::URX_START) begin
        bit_cnt <= 4'h0;
      end else if (state == urx_pkg::URX_DATA && at_last) begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg   <= {rx_pin, shreg[8:1]};
      end
    end
  end

  // A word that finds the buffer full is lost and flagged, never overwritten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end else begin
      push_valid <= frame_ok & keep_word;
      push_data  <= {is_address, word};
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_error_flag <= 1'b0;
      irq_flag           <= 1'b0;
      rda_prev           <= 1'b0;
      uart_irq           <= 1'b0;
    end else begin
      rda_prev           <= receive_data_available_flag;
      overrun_error_flag <= overrun_set | (overrun_error_flag & ~clr_overrun);
      irq_flag           <= irq_set | (irq_flag & ~clr_irq);
      uart_irq           <= irq_set | (irq_flag & ~clr_irq);
    end
  end

  // ****************************************
  // Wake from low power
  // ****************************************
  // Clocked by the pin itself so the edge is caught while clk is stopped
  always_ff @(negedge rx_pin or negedge wake_arm_n) begin
    if (!wake_arm_n) begin
      wake_edge <= 1'b0;
    end else begin
      wake_edge <= wake_gate;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1  <= 1'b0;
      wake_s2  <= 1'b0;
      wake_req <= 1'b0;
      wake_clr <= 1'b0;
    end else begin
      wake_s1  <= wake_edge;
      wake_s2  <= wake_s1;
      wake_req <= wake_s2;
      wake_clr <= wake_s2 & ~low_power_mode;
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) rd_mux[7:0] = ctrl;
    if (sel_div) rd_mux[7:0] = divisor;
    if (sel_cfg) rd_mux[urx_pkg::CFG_WORD_LEN] = word_length_select;
    if (sel_status) begin
      rd_mux[urx_pkg::ST_DATA_AVAIL] = receive_data_available_flag;
      rd_mux[urx_pkg::ST_OVERRUN]    = overrun_error_flag;
      rd_mux[urx_pkg::ST_IRQ]        = irq_flag;
      rd_mux[urx_pkg::ST_WAKE]       = wake_req;
      rd_mux[urx_pkg::ST_HEAD_ADDR]  = pop_if.valid & pop_if.data[urx_pkg::DATA_ADDR];
    end
    if (sel_data && pop_if.valid) rd_mux[urx_pkg::ENTRY_W-1:0] = pop_if.data;
  end

  // One wait cycle per access; read data latched on the same edge that drops waitrequest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest        <= 1'b1;
      readdata           <= 32'h0000_0000;
      ctrl               <= urx_pkg::CTRL_RESET;
      divisor            <= urx_pkg::DIVISOR_RESET;
      word_length_select <= 1'b0;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (read && waitrequest) begin
        readdata <= rd_mux;
      end
      if (wr_ok && sel_ctrl) begin
        ctrl <= writedata[7:0];
      end
      if (wr_ok && sel_div) begin
        divisor <= writedata[7:0];
      end
      if (wr_ok && sel_cfg) begin
        word_length_select <= writedata[urx_pkg::CFG_WORD_LEN];
      end
    end
  end

endmodule // urx_rx_ctrl

// ### core/urx_pkg.sv
// Package of constants and types for the UART receive control block
// How it works
// - Speed select bit picks low or high speed
// - Address detection runs only when enabled
// - Marker is bit seven or ninth bit
// - Marker set means word is an address
// - Address words raise interrupt when enabled
// - Marker clear words dropped, no interrupt
// - Receive falling edge wakes from low power
// - Wake disabled ignores receive pin edges
// - Receive enable passes overrun/data flags to request
// - Receive disabled leaves request flag untouched
// - Bit rate is clock over 64(N+1) or 16(N+1)
// - Length bit picks 8 or 9-bit words
package urx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_DIVISOR  = 5'h04;
  localparam logic [4:0]  OFF_CONFIG   = 5'h08;
  localparam logic [4:0]  OFF_STATUS   = 5'h0C;
  localparam logic [4:0]  OFF_DATA     = 5'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          CTRL_BAUD_HIGH = 5;
  localparam int          CTRL_ADDR_DET  = 4;
  localparam int          CTRL_WAKE_EN   = 3;
  localparam int          CTRL_RX_IRQ_EN = 2;
  localparam int          CFG_WORD_LEN   = 0;
  localparam int          ST_DATA_AVAIL  = 0;
  localparam int          ST_OVERRUN     = 1;
  localparam int          ST_IRQ         = 2;
  localparam int          ST_WAKE        = 3;
  localparam int          ST_HEAD_ADDR   = 4;
  localparam int          DATA_NINTH     = 8;
  localparam int          DATA_ADDR      = 9;
  localparam int          BIT_SEVEN      = 7;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  DIVISOR_RESET  = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          OVERSAMPLE     = 16;
  localparam logic [3:0]  SAMPLE_MID     = 4'h7;
  localparam logic [3:0]  SAMPLE_LAST    = 4'hF;
  localparam logic [1:0]  LOW_PRESCALE   = 2'h3;
  localparam logic [3:0]  BITS_SHORT     = 4'h8;
  localparam logic [3:0]  BITS_LONG      = 4'h9;
  localparam int          WORD_W         = 9;
  localparam int          ENTRY_W        = 10;

  typedef enum logic [1:0] {
    URX_IDLE  = 2'b00,
    URX_START = 2'b01,
    URX_DATA  = 2'b11,
    URX_STOP  = 2'b10
  } urx_state_t;

endpackage

// ### core/urx_stream_if.sv
// Valid/ready stream carrier between receiver and buffer
`timescale 1ns/10ps
interface urx_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### core/urx_baud_gen.sv
// Oversample tick generator for the receive bit clock
`timescale 1ns/10ps
module urx_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             high_speed,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [1:0]       pre;
  logic [DIV_W-1:0] cnt;
  wire              pre_done = high_speed | (pre == urx_pkg::LOW_PRESCALE);
  wire              cnt_done = (cnt == divisor);

  // Sixteen ticks per bit: N+1 clocks each in high speed, four times that in low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre  <= 2'h0;
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      pre  <= pre_done ? 2'h0 : pre + 2'h1;
      if (pre_done) begin
        cnt <= cnt_done ? '0 : cnt + 1'b1;
      end
      tick <= pre_done & cnt_done;
    end
  end
endmodule // urx_baud_gen

// ### core/urx_buffer.sv
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/10ps
module urx_buffer #(
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  urx_stream_if.snk wr,
  urx_stream_if.src rd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [urx_pkg::ENTRY_W-1:0] mem [DEPTH];
  logic [PW-1:0]               wr_ptr;
  logic [PW-1:0]               rd_ptr;
  logic [CW-1:0]               count;

  wire do_wr = wr.valid & wr.ready;
  wire do_rd = rd.valid & rd.ready;

  assign wr.ready = (count != CW'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + CW'(do_wr) - CW'(do_rd);
    end
  end

  // Data storage needs no reset; valid gates it
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr.data;
    end
  end
endmodule // urx_buffer

// ### testbench/urx_rx_ctrl_props.sv
// Assertion checker for the receive control block
`timescale 1ns/10ps
module urx_rx_ctrl_props #(
  parameter int DEPTH = 2
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        rx_pin,
  input wire logic        low_power_mode,
  input wire logic        uart_irq,
  input wire logic        wake_req
);
  // ****************************************
  // Shadow of the control register
  // ****************************************
  logic [7:0] ctrl_q;
  wire        ctrl_wr  = write && !waitrequest && (address == urx_pkg::OFF_CTRL);
  wire        st_clr   = write && !waitrequest && (address == urx_pkg::OFF_STATUS) && writedata[2];
  wire        unmapped = (address[1:0] != 2'h0) || (address > urx_pkg::OFF_DATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_q <= writedata[7:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Properties
  // ****************************************
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not one cycle late");
  wait_drop_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (read && !waitrequest && unmapped |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (read && !waitrequest |-> readdata[31:10] == 22'h0)
    else $error("upper read bits not zero");
  wake_rise_a: assert property (low_power_mode && ctrl_q[3] && $fell(rx_pin) |-> ##[1:6] wake_req)
    else $error("wake missed");
  wake_off_a: assert property ((!ctrl_q[3] && !wake_req) [*4] |=> !wake_req)
    else $error("wake while disabled");
  wake_src_a: assert property ($rose(wake_req) |-> low_power_mode)
    else $error("wake outside low power");
  wake_release_a: assert property ($fell(low_power_mode) |-> ##[1:6] !wake_req)
    else $error("wake not released");
  irq_gate_a: assert property ($rose(uart_irq) |-> $past(ctrl_q[2]))
    else $error("irq while masked");
  irq_hold_a: assert property (uart_irq && !st_clr |=> uart_irq)
    else $error("irq dropped without clear");

  wake_c: cover property ($rose(wake_req));
  irq_c: cover property ($rose(uart_irq));
  unmapped_c: cover property (read && !waitrequest && unmapped);
  addr_word_c: cover property (read && !waitrequest && (address == urx_pkg::OFF_DATA) && readdata[9]);
endmodule // urx_rx_ctrl_props

// ### testbench/urx_serial_tx.sv
// Behavioural model of the remote serial transmitter
`timescale 1ns/10ps
module urx_serial_tx (
  input  wire logic clk,
  output logic      line
);
  // Line idles high between frames
  initial line = 1'b1;

  // Start, data LSB first, one stop bit; bc clocks per bit
  task automatic send(input logic [8:0] w, input int nb, input int bc);
    @(posedge clk);
    line <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line <= w[i];
      repeat (bc) @(posedge clk);
    end
    line <= 1'b1;
    repeat (bc) @(posedge clk);
  endtask
endmodule // urx_serial_tx

// ### testbench/urx_rx_ctrl_test.sv
// Testbench for the receive control block
`timescale 1ns/10ps
module urx_rx_ctrl_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_pin;
  logic        low_power_mode = 1'b0;
  logic        uart_irq;
  logic        wake_req;
  logic [31:0] q;
  int          fails = 0;
  int          n_compared = 0;

  always #25 clk = ~clk;

  urx_serial_tx i_urx_serial_tx (.clk(clk), .line(rx_pin));
  urx_rx_ctrl #(.DEPTH(2)) i_urx_rx_ctrl (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rx_pin(rx_pin), .low_power_mode(low_power_mode), .uart_irq(uart_irq), .wake_req(wake_req));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      $display("wrong value bus answer expected 0 seen %b", waitrequest);
      fails++;
      close_out();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask

  task automatic tx(input logic [8:0] w, input int nb, input int bc);
    i_urx_serial_tx.send(w, nb, bc);
  endtask

  // Irq and wake seen once the last edge has landed
  task automatic fl(input string nm, input logic [1:0] exp);
    repeat (2) @(posedge clk);
    chk(nm, {30'h0, exp}, {30'h0, uart_irq, wake_req});
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd("ctrl reset", urx_pkg::OFF_CTRL, 32'h0);
    rd("divisor reset", urx_pkg::OFF_DIVISOR, 32'h0);
    wr(5'h14, 32'hFF);
    rd("unmapped", 5'h14, 32'h0);
    tx(9'h0A5, 8, 64);
    rd("low speed word", urx_pkg::OFF_DATA, 32'h0A5);
    wr(urx_pkg::OFF_DIVISOR, 32'h1);
    wr(urx_pkg::OFF_CTRL, 32'h24);
    tx(9'h05A, 8, 32);
    fl("irq set", 2'b10);
    rd("high speed word", urx_pkg::OFF_DATA, 32'h05A);
    wr(urx_pkg::OFF_STATUS, 32'h4);
    fl("irq cleared", 2'b00);
    wr(urx_pkg::OFF_CTRL, 32'h20);
    tx(9'h0B3, 8, 32);
    fl("irq masked", 2'b00);
    rd("plain word", urx_pkg::OFF_DATA, 32'h0B3);
    wr(urx_pkg::OFF_CTRL, 32'h34);
    tx(9'h085, 8, 32);
    fl("address irq", 2'b10);
    rd("address status", urx_pkg::OFF_STATUS, 32'h15);
    rd("address word", urx_pkg::OFF_DATA, 32'h285);
    wr(urx_pkg::OFF_STATUS, 32'h4);
    tx(9'h005, 8, 32);
    rd("data dropped", urx_pkg::OFF_STATUS, 32'h0);
    wr(urx_pkg::OFF_CONFIG, 32'h1);
    tx(9'h112, 9, 32);
    rd("ninth marker", urx_pkg::OFF_DATA, 32'h312);
    wr(urx_pkg::OFF_STATUS, 32'h4);
    tx(9'h0FF, 9, 32);
    rd("ninth dropped", urx_pkg::OFF_STATUS, 32'h0);
    wr(urx_pkg::OFF_CTRL, 32'h20);
    tx(9'h1AB, 9, 32);
    rd("nine bit data", urx_pkg::OFF_DATA, 32'h1AB);
    wr(urx_pkg::OFF_CONFIG, 32'h0);
    // Third word meets a full buffer and must be refused
    for (int i = 1; i < 4; i++) begin
      tx({1'b0, 8'(8'h11 * i)}, 8, 32);
    end
    rd("full status", urx_pkg::OFF_STATUS, 32'h3);
    rd("first kept", urx_pkg::OFF_DATA, 32'h011);
    rd("second kept", urx_pkg::OFF_DATA, 32'h022);
    rd("overrun held", urx_pkg::OFF_STATUS, 32'h2);
    wr(urx_pkg::OFF_STATUS, 32'h2);
    rd("overrun cleared", urx_pkg::OFF_STATUS, 32'h0);
    low_power_mode <= 1'b1;
    tx(9'h044, 8, 32);
    fl("wake off", 2'b00);
    wr(urx_pkg::OFF_CTRL, 32'h28);
    tx(9'h055, 8, 32);
    fl("wake on", 2'b01);
    rd("wake status", urx_pkg::OFF_STATUS, 32'h9);
    low_power_mode <= 1'b0;
    repeat (4) @(posedge clk);
    fl("wake released", 2'b00);
    rd("wake status clear", urx_pkg::OFF_STATUS, 32'h1);
    close_out();
  end
endmodule // urx_rx_ctrl_test

bind urx_rx_ctrl urx_rx_ctrl_props #(.DEPTH(DEPTH)) i_urx_rx_ctrl_props (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .rx_pin(rx_pin), .low_power_mode(low_power_mode), .uart_irq(uart_irq),
  .wake_req(wake_req));
